// file: spi_buf_map.vh
// register map and field constants for the buffer status block
`ifndef SPI_BUF_MAP_VH
`define SPI_BUF_MAP_VH
`define ADDR_STATUS      4'h0
`define ADDR_RXBUF       4'h4
`define ADDR_TXBUF       4'h8
`define ADDR_IRQ_STATUS  4'hC
`define ADDR_IRQ_MASK    4'h0
`define ADDR_IRQ_MASK_W  4'h0
`define BIT_TX_WRITE_ERROR         7
`define BIT_TX_FIFO_EMPTY_FLAG         5
`define BIT_RX_READ_ERROR         3
`define BIT_FLUSH        2
`define BIT_RX_FIFO_FULL_FLAG         0
`define IRQ_TX_WRITE_ERROR         0
`define IRQ_RX_READ_ERROR         1
`define IRQ_WIDTH        2
`define ADDR_MASK        5'h10
`define ADDR_WIDTH       5
`define STATUS_IMPL      8'hA9
`define STATUS_BITS      8
`endif

// file: byte_fifo.v
// synchronous byte queue with flush
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH_LOG2 = 3
) (
	input  wire             clock,
	input  wire             sys_rst,
	input  wire             flush,
	input  wire             pushValid,
	input  wire [WIDTH-1:0] pushData,
	output wire             pushReady,
	input  wire             popReady,
	output wire             popValid,
	output wire [WIDTH-1:0] popData,
	output wire [DEPTH_LOG2:0] level
);
	localparam DEPTH = 1 << DEPTH_LOG2;
	reg [WIDTH-1:0]      mem [0:DEPTH-1];
	reg [DEPTH_LOG2:0]   wrPtr_q;
	reg [DEPTH_LOG2:0]   rdPtr_q;
	wire                 doPush;
	wire                 doPop;

	assign level     = wrPtr_q - rdPtr_q;
	assign popValid  = (level != {(DEPTH_LOG2+1){1'b0}});
	assign pushReady = (level[DEPTH_LOG2] == 1'b0);
	assign popData   = mem[rdPtr_q[DEPTH_LOG2-1:0]];
	assign doPush    = pushValid & pushReady & ~flush;
	assign doPop     = popReady & popValid & ~flush;

	always @(posedge clock) begin
		if (doPush)
			mem[wrPtr_q[DEPTH_LOG2-1:0]] <= pushData;
	end

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_q <= {(DEPTH_LOG2+1){1'b0}};
			rdPtr_q <= {(DEPTH_LOG2+1){1'b0}};
		end else if (flush) begin
			wrPtr_q <= {(DEPTH_LOG2+1){1'b0}};
			rdPtr_q <= {(DEPTH_LOG2+1){1'b0}};
		end else begin
			if (doPush)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (doPop)
				rdPtr_q <= rdPtr_q + 1'b1;
		end
	end
endmodule // byte_fifo
`default_nettype wire

// file: spi_buffer_status.v
// buffer status, receive read and transmit write logic of the serial port
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "spi_buf_map.vh"

// Behaviour
// - writing transmit buffer while transmit queue full sets tx write error
// - transmit empty flag reads 1 while transmit queue empty; reset 1
// - reading receive buffer while receive queue empty sets rx read error
// - writing 1 to flush bit empties both queues; 0 does nothing
// - receive full flag reads 1 exactly when receive queue full
// - receive buffer read returns oldest byte, removes it
// - empty receive read returns zero, occupancy unchanged, sets error
module spi_buffer_status #(
	parameter DEPTH_LOG2 = 3
) (
	input  wire                  clock,
	input  wire                  sys_rst,
	input  wire                  wb_cyc_i,
	input  wire                  wb_stb_i,
	input  wire                  wb_we_i,
	input  wire [`ADDR_WIDTH-1:0] wb_adr_i,
	input  wire [31:0]           wb_dat_i,
	input  wire [3:0]            wb_sel_i,
	output reg  [31:0]           wb_dat_o,
	output reg                   wb_ack_o,
	input  wire                  rxPushValid,
	input  wire [7:0]            rxPushData,
	output wire                  rxPushReady,
	input  wire                  txPopReady,
	output wire                  txPopValid,
	output wire [7:0]            txPopData,
	output wire [DEPTH_LOG2:0]   rxLevel,
	output wire [DEPTH_LOG2:0]   txLevel,
	output wire                  irq
);
	// ==========================================================
	// bus decode
	wire        req;
	wire        wrStrobe;
	wire        rdStrobe;
	wire        lane0;
	wire        selStatus;
	wire        selRx;
	wire        selTx;
	wire        selIrq;
	wire        selMask;
	reg         txWriteErr_q;
	reg         rxReadErr_q;
	reg  [`IRQ_WIDTH-1:0] irqMask_q;
	wire        rxEmpty;
	wire        rxFull;
	wire        txEmpty;
	wire        txFull;
	wire        flushNow;
	wire [7:0]  rxHead;
	wire        rxPopValid;
	wire        txPushReady;
	wire        rxRead;
	wire        txWrite;
	wire        setTxErr;
	wire        setRxErr;
	wire [7:0]  statusByte;
	wire [`IRQ_WIDTH-1:0] irqStatus;
	wire        statusWrite;
	wire        txBufWrite;
	wire        rxBufRead;
	wire        maskWrite;
	wire        clrTxErr;
	wire        clrRxErr;
	wire [7:0]  statusRaw;
	wire [7:0]  statusImpl;
	reg  [31:0] readWord_d;

	assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrStrobe = req & wb_we_i;
	assign rdStrobe = req & ~wb_we_i;
	assign lane0    = wb_sel_i[0];

	assign selStatus = (wb_adr_i == {1'b0, `ADDR_STATUS});
	assign selRx     = (wb_adr_i == {1'b0, `ADDR_RXBUF});
	assign selTx     = (wb_adr_i == {1'b0, `ADDR_TXBUF});
	assign selIrq    = (wb_adr_i == {1'b0, `ADDR_IRQ_STATUS});
	assign selMask   = (wb_adr_i == `ADDR_MASK);

	// ==========================================================
	// queues
	assign rxEmpty = ~rxPopValid;
	assign txFull  = ~txPushReady;
	assign rxFull  = ~rxPushReady;
	assign txEmpty = ~txPopValid;

	// ==========================================================
	// write and read decode
	assign statusWrite = wrStrobe & selStatus & lane0;
	assign txBufWrite  = wrStrobe & selTx & lane0;
	assign rxBufRead   = rdStrobe & selRx;
	assign maskWrite   = wrStrobe & selMask & lane0;
	assign clrTxErr    = statusWrite & wb_dat_i[`BIT_TX_WRITE_ERROR];
	assign clrRxErr    = statusWrite & wb_dat_i[`BIT_RX_READ_ERROR];
	assign flushNow    = statusWrite & wb_dat_i[`BIT_FLUSH];
	assign rxRead      = rxBufRead & ~rxEmpty;
	assign txWrite     = txBufWrite & ~txFull;
	assign setTxErr    = txBufWrite & txFull;
	assign setRxErr    = rxBufRead & rxEmpty;

	byte_fifo #(
		.WIDTH      (8),
		.DEPTH_LOG2 (DEPTH_LOG2)
	) rxQueue (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.flush     (flushNow),
		.pushValid (rxPushValid),
		.pushData  (rxPushData),
		.pushReady (rxPushReady),
		.popReady  (rxRead),
		.popValid  (rxPopValid),
		.popData   (rxHead),
		.level     (rxLevel)
	);

	byte_fifo #(
		.WIDTH      (8),
		.DEPTH_LOG2 (DEPTH_LOG2)
	) txQueue (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.flush     (flushNow),
		.pushValid (txWrite),
		.pushData  (wb_dat_i[7:0]),
		.pushReady (txPushReady),
		.popReady  (txPopReady),
		.popValid  (txPopValid),
		.popData   (txPopData),
		.level     (txLevel)
	);

	// ==========================================================
	// status byte
	assign statusRaw  = {txWriteErr_q, 1'b0, txEmpty, 1'b0,
		rxReadErr_q, 1'b0, 1'b0, rxFull};
	assign statusImpl = `STATUS_IMPL;

	// ==========================================================
	// unimplemented bits forced to zero
	genvar g;
	generate
		for (g = 0; g < `STATUS_BITS; g = g + 1) begin : statusBit
			assign statusByte[g] = statusRaw[g] & statusImpl[g];
		end
	endgenerate

	// ==========================================================
	// error flags and interrupt
	// set wins over a clear in the same cycle
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			txWriteErr_q <= 1'b0;
		end else if (setTxErr) begin
			txWriteErr_q <= 1'b1;
		end else if (clrTxErr) begin
			txWriteErr_q <= 1'b0;
		end
	end

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rxReadErr_q <= 1'b0;
		end else if (setRxErr) begin
			rxReadErr_q <= 1'b1;
		end else if (clrRxErr) begin
			rxReadErr_q <= 1'b0;
		end
	end

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irqMask_q <= {`IRQ_WIDTH{1'b0}};
		end else if (maskWrite) begin
			irqMask_q <= wb_dat_i[`IRQ_WIDTH-1:0];
		end
	end

	assign irqStatus = {rxReadErr_q, txWriteErr_q};
	assign irq = |(irqStatus & irqMask_q);

	// ==========================================================
	// read mux
	always @* begin
		readWord_d = 32'h00000000;
		if (selStatus) begin
			readWord_d[7:0] = statusByte;
		end else if (selRx) begin
			readWord_d[7:0] = rxEmpty ? 8'h00 : rxHead;
		end else if (selIrq) begin
			readWord_d[`IRQ_WIDTH-1:0] = irqStatus;
		end else if (selMask) begin
			readWord_d[`IRQ_WIDTH-1:0] = irqMask_q;
		end
	end

	// ==========================================================
	// bus answer
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			if (rdStrobe) begin
				wb_dat_o <= readWord_d;
			end
		end
	end
endmodule // spi_buffer_status
`default_nettype wire

// file: buf_status_chk_sva.sv
// assertion checker for the buffer status block
`timescale 1ns/1ps
`default_nettype none
`include "spi_buf_map.vh"
module buf_status_chk #(
	parameter DEPTH_LOG2 = 3
) (
	input wire logic                clock,
	input wire logic                sys_rst,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_we_i,
	input wire logic [4:0]          wb_adr_i,
	input wire logic [31:0]         wb_dat_i,
	input wire logic [3:0]          wb_sel_i,
	input wire logic [31:0]         wb_dat_o,
	input wire logic                wb_ack_o,
	input wire logic                rxPushValid,
	input wire logic                rxPushReady,
	input wire logic                txPopReady,
	input wire logic [DEPTH_LOG2:0] rxLevel,
	input wire logic [DEPTH_LOG2:0] txLevel
);
	// ========================================
	// properties
	localparam [DEPTH_LOG2:0] FULL = 1 << DEPTH_LOG2;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire logic rq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic rd = rq & ~wb_we_i;
	wire logic wr = rq & wb_we_i & wb_sel_i[0];
	wire logic st = wb_adr_i == `ADDR_STATUS;
	wire logic rb = rd & (wb_adr_i == `ADDR_RXBUF) & ~rxPushValid;
	AST_ACK: assert property (rq |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse");
	AST_TX_FIFO_EMPTY_FLAG: assert property (rd && st |=>
		wb_dat_o[`BIT_TX_FIFO_EMPTY_FLAG] == ($past(txLevel) == 0)) else $error("tx empty");
	AST_RX_FIFO_FULL_FLAG: assert property (rd && st |=>
		wb_dat_o[`BIT_RX_FIFO_FULL_FLAG] == ($past(rxLevel) == FULL)) else $error("rx full");
	AST_UNIMP: assert property (rd && st |=>
		{wb_dat_o[31:8], wb_dat_o[6], wb_dat_o[4], wb_dat_o[1]} == 0)
		else $error("unused bits set");
	AST_READY: assert property (rxPushReady == (rxLevel != FULL))
		else $error("push ready wrong");
	AST_POP: assert property (rb && rxLevel != 0 |=>
		rxLevel == $past(rxLevel) - 1) else $error("pop count");
	AST_EMPTY: assert property (rb && rxLevel == 0 |=>
		wb_dat_o == 0 && rxLevel == 0) else $error("empty read");
	AST_DISCARD: assert property (wr && wb_adr_i == `ADDR_TXBUF &&
		txLevel == FULL && !txPopReady |=> txLevel == FULL)
		else $error("full write kept");
	AST_FLUSH: assert property (wr && st && wb_dat_i[`BIT_FLUSH] |=>
		rxLevel == 0 && txLevel == 0) else $error("flush");
endmodule // buf_status_chk
bind spi_buffer_status buf_status_chk #(.DEPTH_LOG2(DEPTH_LOG2)) chk_u (
	.clock, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
	.wb_sel_i, .wb_dat_o, .wb_ack_o, .rxPushValid, .rxPushReady, .txPopReady,
	.rxLevel, .txLevel);
`default_nettype wire

// file: tb.sv
// self-checking bench for the buffer status block
`timescale 1ns/1ps
`default_nettype none
`include "spi_buf_map.vh"
module tb;
	logic        clock, sys_rst, cyc, stb, we, rxV, txR, ack, irq;
	logic        rxRdy, txV;
	logic [7:0]  txD;
	logic [4:0]  adr;
	logic [31:0] dat, datO, q[$];
	logic [7:0]  rxD, b[8];
	logic [3:0]  rxLvl, txLvl;
	int          failures, cmp_count, cycN, i;
	// ========================================
	// design
	spi_buffer_status dut_u (.clock, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1),
		.wb_dat_o(datO), .wb_ack_o(ack), .rxPushValid(rxV), .rxPushData(rxD),
		.rxPushReady(rxRdy), .txPopReady(txR), .txPopValid(txV),
		.txPopData(txD),
		.rxLevel(rxLvl), .txLevel(txLvl), .irq);
	// ========================================
	// tasks
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
		if (!w) q.push_back({24'h0, d});
		do @(posedge clock); while (ack !== 1'b1);
		{cyc, stb} <= 2'b00;
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ========================================
	// monitor and stimulus
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (ack === 1'b1 && we === 1'b0) chk("rd", datO, q.pop_front());
		cycN++;
		if (cycN > 500) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		sys_rst = 1;
		{cyc, stb, we, adr, dat, rxV, rxD, txR} = 0;
		failures = 0;
		cmp_count = 0;
		cycN = 0;
		void'($urandom(32'h4097));
		repeat (4) @(posedge clock);
		sys_rst <= 0;
		for (i = 0; i < 8; i++) begin
			b[i] = $urandom;
			{rxV, rxD} <= {1'b1, b[i]};
			@(posedge clock);
		end
		rxV <= 0;
		bus(0, `ADDR_STATUS, 8'h21);
		chk("rx ready", {31'h0, rxRdy}, 0);
		for (i = 0; i < 8; i++) bus(0, `ADDR_RXBUF, b[i]);
		bus(0, `ADDR_RXBUF, 8'h00);
		bus(0, `ADDR_STATUS, 8'h28);
		$display("receive test done");
		chk("irq", {31'h0, irq}, 0);
		bus(1, `ADDR_MASK, 8'h02);
		chk("irq", {31'h0, irq}, 1);
		bus(1, `ADDR_STATUS, 8'h08);
		chk("irq", {31'h0, irq}, 0);
		bus(0, `ADDR_STATUS, 8'h20);
		for (i = 0; i < 9; i++) bus(1, `ADDR_TXBUF, i[7:0]);
		bus(0, `ADDR_STATUS, 8'h80);
		chk("tx head", {23'h0, txV, txD}, 32'h00000100);
		chk("tx level", {28'h0, txLvl}, 8);
		bus(1, `ADDR_STATUS, 8'h04);
		chk("flush level", {28'h0, txLvl}, 0);
		bus(0, `ADDR_STATUS, 8'hA0);
		bus(1, `ADDR_STATUS, 8'h80);
		bus(0, `ADDR_STATUS, 8'h20);
		bus(0, 5'h14, 8'h00);
		$display("transmit test done");
		@(posedge clock);
		complete_run();
	end
endmodule // tb
`default_nettype wire
